//--- src/ptps_cfg.svh
// Constants of the periodic timer: offsets, field positions, reset values and timing counts.
`ifndef PTPS_CFG_SVH
`define PTPS_CFG_SVH

// ****************************************************************
// Register indices; each register is one aligned word at four times its index
// ****************************************************************
`define PTPS_IDX_INTCTL 8'h0B
`define PTPS_IDX_FLAGS 8'h0C
`define PTPS_IDX_COUNT 8'h11
`define PTPS_IDX_CTRL 8'h12
`define PTPS_IDX_ENABLES 8'h8C
`define PTPS_IDX_PERIOD 8'h92

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define PTPS_FLAG_BIT 1
`define PTPS_GIE_BIT 7
`define PTPS_PEIE_BIT 6
`define PTPS_CTRL_MASK 8'h7F
`define PTPS_COUNT_RST 8'h00
`define PTPS_CTRL_RST 8'h00
`define PTPS_PERIOD_RST 8'hFF
`define PTPS_INTCTL_RST 8'h00

// ****************************************************************
// Timing counts
// ****************************************************************
`define PTPS_CORE_DIV 2'h3

`endif

//--- src/ptps_pkg.sv
// Types of the periodic timer.
package ptps_pkg;
    typedef struct packed {
        logic unused;
        logic [3:0] postscale_select;
        logic timer_run;
        logic [1:0] prescale_select;
    } ptps_ctrl_t;

    typedef struct packed {
        logic [7:0] count;
        logic match;
    } ptps_pwm_t;

    typedef enum logic [1:0] {
        PTPS_IDLE = 2'b01,
        PTPS_ACCESS = 2'b10
    } ptps_bus_state_t;
endpackage

//--- src/ptps_timer.sv
// Periodic 8-bit timer with prescaler, period compare and postscaler behind APB.
//
// Chosen here: the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "ptps_cfg.svh"

module ptps_timer (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic clk_en_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [31:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [3:0] pstrb_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    output logic irq_out,
    output logic ssp_shift_tick_out,
    output ptps_pkg::ptps_pwm_t pwm_out
);

    // ****************************************************************
    // Register decode
    // ****************************************************************
    // Registers sit on word boundaries, so the index is taken from bits 9:2 of the byte address.
    // Byte-lane bits 1:0 must be zero, which keeps a misaligned access from aliasing a register.
    function automatic logic is_reg(input logic [31:0] addr, input logic [7:0] idx);
        is_reg = (addr[31:10] == 22'h000000) && (addr[9:2] == idx) && (addr[1:0] == 2'h0);
    endfunction

    function automatic logic is_mapped(input logic [31:0] addr);
        is_mapped = is_reg(addr, `PTPS_IDX_INTCTL) || is_reg(addr, `PTPS_IDX_FLAGS) ||
            is_reg(addr, `PTPS_IDX_COUNT) || is_reg(addr, `PTPS_IDX_CTRL) ||
            is_reg(addr, `PTPS_IDX_ENABLES) || is_reg(addr, `PTPS_IDX_PERIOD);
    endfunction

    ptps_pkg::ptps_bus_state_t state_q;
    logic [7:0] count_q;
    ptps_pkg::ptps_ctrl_t ctrl_q;
    logic [7:0] period_q;
    logic [7:0] intctl_q;
    logic match_flag_q;
    logic match_irq_enable_q;
    logic [1:0] core_div_q;
    logic [3:0] pre_q;
    logic [3:0] post_q;

    logic access;
    logic wr;
    logic wr_low;
    logic wr_count;
    logic wr_ctrl;
    logic wr_period;
    logic wr_intctl;
    logic wr_flags;
    logic wr_enables;
    logic instr_tick;
    logic pre_done;
    logic count_tick;
    logic match;
    logic post_done;
    logic [3:0] pre_limit;

    // The slave answers in the first access cycle, so every transfer takes two cycles.
    assign access = psel_in && penable_in && clk_en_in;
    assign wr = access && pwrite_in && is_mapped(paddr_in);
    assign wr_low = wr && pstrb_in[0];
    assign wr_count = wr_low && is_reg(paddr_in, `PTPS_IDX_COUNT);
    assign wr_ctrl = wr_low && is_reg(paddr_in, `PTPS_IDX_CTRL);
    assign wr_period = wr_low && is_reg(paddr_in, `PTPS_IDX_PERIOD);
    assign wr_intctl = wr_low && is_reg(paddr_in, `PTPS_IDX_INTCTL);
    assign wr_flags = wr_low && is_reg(paddr_in, `PTPS_IDX_FLAGS);
    assign wr_enables = wr_low && is_reg(paddr_in, `PTPS_IDX_ENABLES);

    // ****************************************************************
    // APB handshake
    // ****************************************************************
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_q <= ptps_pkg::PTPS_IDLE;
        end else if (clk_en_in) begin
            case (state_q)
                ptps_pkg::PTPS_IDLE: begin
                    if (psel_in && !penable_in) begin
                        state_q <= ptps_pkg::PTPS_ACCESS;
                    end
                end
                ptps_pkg::PTPS_ACCESS: begin
                    state_q <= ptps_pkg::PTPS_IDLE;
                end
                default: begin
                    state_q <= ptps_pkg::PTPS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out <= 32'h00000000;
        end else if (clk_en_in) begin
            pready_out <= psel_in && !penable_in;
            pslverr_out <= psel_in && !penable_in && !is_mapped(paddr_in);
            prdata_out <= 32'h00000000;
            if (psel_in && !penable_in && !pwrite_in) begin
                if (is_reg(paddr_in, `PTPS_IDX_COUNT)) begin
                    prdata_out <= {24'h000000, count_q};
                end else if (is_reg(paddr_in, `PTPS_IDX_CTRL)) begin
                    prdata_out <= {24'h000000, 1'b0, ctrl_q[6:0]};
                end else if (is_reg(paddr_in, `PTPS_IDX_PERIOD)) begin
                    prdata_out <= {24'h000000, period_q};
                end else if (is_reg(paddr_in, `PTPS_IDX_INTCTL)) begin
                    prdata_out <= {24'h000000, intctl_q};
                end else if (is_reg(paddr_in, `PTPS_IDX_FLAGS)) begin
                    prdata_out <= {24'h000000, 6'h00, match_flag_q, 1'b0};
                end else if (is_reg(paddr_in, `PTPS_IDX_ENABLES)) begin
                    prdata_out <= {24'h000000, 6'h00, match_irq_enable_q, 1'b0};
                end
            end
        end
    end

    // ****************************************************************
    // Configuration registers
    // ****************************************************************
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ctrl_q <= `PTPS_CTRL_RST;
            period_q <= `PTPS_PERIOD_RST;
            intctl_q <= `PTPS_INTCTL_RST;
            match_irq_enable_q <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= pwdata_in[7:0] & `PTPS_CTRL_MASK;
            end
            if (wr_period) begin
                period_q <= pwdata_in[7:0];
            end
            if (wr_intctl) begin
                intctl_q <= pwdata_in[7:0];
            end
            if (wr_enables) begin
                match_irq_enable_q <= pwdata_in[`PTPS_FLAG_BIT];
            end
        end
    end

    // ****************************************************************
    // Prescaler
    // ****************************************************************
    always_comb begin
        case (ctrl_q.prescale_select)
            2'h0: pre_limit = 4'h0;
            2'h1: pre_limit = 4'h3;
            default: pre_limit = 4'hF;
        endcase
    end

    // The core clock is divided by four first, standing in for the instruction clock.
    assign instr_tick = clk_en_in && (core_div_q == `PTPS_CORE_DIV);
    assign pre_done = instr_tick && ctrl_q.timer_run && (pre_q >= pre_limit);
    assign count_tick = pre_done && !wr_count && !wr_ctrl;
    assign match = count_tick && (count_q == period_q);

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            core_div_q <= 2'h0;
        end else if (clk_en_in) begin
            core_div_q <= core_div_q + 2'h1;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pre_q <= 4'h0;
        end else if (wr_count || wr_ctrl) begin
            pre_q <= 4'h0;
        end else if (instr_tick && ctrl_q.timer_run) begin
            pre_q <= pre_done ? 4'h0 : pre_q + 4'h1;
        end
    end

    // ****************************************************************
    // Counter and postscaler
    // ****************************************************************
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            count_q <= `PTPS_COUNT_RST;
        end else if (wr_count) begin
            count_q <= pwdata_in[7:0];
        end else if (count_tick) begin
            count_q <= match ? 8'h00 : count_q + 8'h01;
        end
    end

    assign post_done = match && (post_q == ctrl_q.postscale_select);

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            post_q <= 4'h0;
        end else if (wr_count || wr_ctrl) begin
            post_q <= 4'h0;
        end else if (match) begin
            post_q <= post_done ? 4'h0 : post_q + 4'h1;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            match_flag_q <= 1'b0;
        end else if (post_done) begin
            match_flag_q <= 1'b1;
        end else if (wr_flags && pwdata_in[`PTPS_FLAG_BIT]) begin
            match_flag_q <= 1'b0;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            irq_out <= 1'b0;
            ssp_shift_tick_out <= 1'b0;
            pwm_out <= '0;
        end else if (clk_en_in) begin
            irq_out <= match_flag_q && match_irq_enable_q;
            ssp_shift_tick_out <= match;
            pwm_out <= {count_q, match};
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    count_wrap_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        match |=> count_q == 8'h00) else $error("count did not wrap on match");
    count_hold_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        !ctrl_q.timer_run && !wr_count |=> $stable(count_q)) else $error("count moved while stopped");
    ctrl_keep_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        wr_ctrl |=> count_q == $past(count_q)) else $error("control write changed count");
    count_write_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        wr_count |=> count_q == $past(pwdata_in[7:0])) else $error("count write lost");
    scaler_clear_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        wr_count |=> pre_q == 4'h0 && post_q == 4'h0) else $error("scalers not cleared on count write");
    ctrl_clear_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        wr_ctrl |=> pre_q == 4'h0 && post_q == 4'h0) else $error("scalers not cleared on control write");
    flag_set_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        post_done |=> match_flag_q) else $error("flag not set on postscale expiry");
    post_range_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        post_q <= ctrl_q.postscale_select || $past(wr_ctrl)) else $error("postscaler overran");
    pre_range_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        pre_done |-> pre_q == pre_limit) else $error("prescaler overran");
    ssp_tick_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        match && clk_en_in |=> ssp_shift_tick_out) else $error("serial tick missing");
    ctrl_msb_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        ctrl_q.unused == 1'b0) else $error("control bit 7 set");


    // ****************************************************************
    // Bus assertions
    // ****************************************************************
    // The answer is a single-cycle pulse, so a master that holds psel cannot see it twice.
    ready_pulse_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        pready_out |=> !pready_out) else $error("ready stood longer than one cycle");

    err_with_ready_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        pslverr_out |-> pready_out) else $error("error without ready");

    rdata_upper_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        prdata_out[31:8] == 24'h000000) else $error("read data upper bits set");

    access_state_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        pready_out |-> state_q == ptps_pkg::PTPS_ACCESS) else $error("ready outside access phase");

    // ****************************************************************
    // Register assertions
    // ****************************************************************
    period_write_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        wr_period |=> period_q == $past(pwdata_in[7:0])) else $error("period write lost");

    ctrl_write_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        wr_ctrl |=> ctrl_q == ($past(pwdata_in[7:0]) & `PTPS_CTRL_MASK)) else $error("control write lost");

    // ****************************************************************
    // Counter assertions
    // ****************************************************************
    count_step_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        count_tick && !match |=> count_q == $past(count_q) + 8'h01) else $error("count did not step");

    post_step_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        match && !post_done |=> post_q == $past(post_q) + 4'h1) else $error("postscaler did not step");

    // A low clock enable must freeze everything, or a stalled core would see the timer drift.
    frozen_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        !clk_en_in |=> $stable(count_q) && $stable(pre_q)) else $error("state moved while frozen");

    stop_pre_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        !ctrl_q.timer_run && !wr_count && !wr_ctrl |=> $stable(pre_q)) else $error("prescaler moved while stopped");

    pwm_follow_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        clk_en_in |=> pwm_out.count == $past(count_q)) else $error("pwm count does not follow");

    // ****************************************************************
    // Flag assertions
    // ****************************************************************
    // The set wins over a clear in the same cycle, so only a clear without expiry is checked here.
    flag_clear_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        wr_flags && pwdata_in[`PTPS_FLAG_BIT] && !post_done |=> !match_flag_q) else $error("flag not cleared");

    flag_hold_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        match_flag_q && !wr_flags |=> match_flag_q) else $error("flag dropped by itself");

    irq_source_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        irq_out |-> $past(match_flag_q)) else $error("interrupt without flag");

    // ****************************************************************
    // Cover properties
    // ****************************************************************
    match_seen_c: cover property (@(posedge clk_in) disable iff (!reset_n_in) match);
    pre16_seen_c: cover property (@(posedge clk_in) disable iff (!reset_n_in) pre_done && ctrl_q.prescale_select[1]);
    ctrl_run_c: cover property (@(posedge clk_in) disable iff (!reset_n_in) wr_ctrl && ctrl_q.timer_run);
    flag_seen_c: cover property (@(posedge clk_in) disable iff (!reset_n_in) post_done && post_q != 4'h0);
    irq_seen_c: cover property (@(posedge clk_in) disable iff (!reset_n_in) irq_out);

endmodule
`default_nettype wire

//--- verif/tb_top.sv
// Self-checking testbench of the periodic timer.
`timescale 1ns/100ps
`default_nettype none
`include "ptps_cfg.svh"
module tb_top;
    logic clk_in, reset_n_in, clk_en_in, psel_in, penable_in, pwrite_in;
    logic [31:0] paddr_in, pwdata_in, prdata_out, rdv;
    logic [3:0] pstrb_in, post;
    logic pready_out, pslverr_out, irq_out, ssp_shift_tick_out, err_q;
    ptps_pkg::ptps_pwm_t pwm_out;
    logic [7:0] per, cur_per;
    logic [1:0] pre;
    int n_errors, checked, seed, pulses, stamp, gap, cyc, p0;

    // ********************
    // Design and monitor
    // ********************
    ptps_timer i_ptps_timer (.clk_in(clk_in), .reset_n_in(reset_n_in), .clk_en_in(clk_en_in),
        .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
        .pwdata_in(pwdata_in), .pstrb_in(pstrb_in), .prdata_out(prdata_out), .pready_out(pready_out),
        .pslverr_out(pslverr_out), .irq_out(irq_out), .ssp_shift_tick_out(ssp_shift_tick_out),
        .pwm_out(pwm_out));

    initial begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end

    // The count is only bounded by the period while the period is never lowered below it.
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (reset_n_in === 1'b1) begin
            check1("pwm_match", ssp_shift_tick_out, pwm_out.match);
            check1("count_in_range", 1'b1, pwm_out.count <= cur_per);
            if (ssp_shift_tick_out === 1'b1) begin
                pulses <= pulses + 1;
                gap <= cyc - stamp;
                stamp <= cyc;
            end
        end
    end

    // ********************
    // Tasks and functions
    // ********************
    task automatic check1(input string what, input logic exp, input logic got);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic checkv(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic tally_and_finish();
        if (n_errors == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic give_up();
        n_errors++;
        $display("CHECK FAILED wait expected done seen timeout");
        tally_and_finish();
    endtask

    // One idle cycle follows each transfer so psel is never driven twice in one time step.
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        int w;
        psel_in <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in <= wr;
        paddr_in <= {22'h0, idx, 2'h0};
        pwdata_in <= {24'h0, wd};
        @(posedge clk_in);
        penable_in <= 1'b1;
        w = 0;
        do begin
            @(posedge clk_in);
            w++;
        end while (pready_out !== 1'b1 && w < 40);
        if (w >= 40) give_up();
        rdv = prdata_out;
        err_q = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        @(posedge clk_in);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d);
    endtask

    task automatic rdchk(input string what, input logic [7:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 8'h00);
        checkv(what, {24'h0, exp}, rdv);
    endtask

    task automatic wait_pulses(input int target);
        int w;
        w = 0;
        while (pulses < target) begin
            @(posedge clk_in);
            w++;
            if (w > 20000) give_up();
        end
    endtask

    task automatic do_reset();
        reset_n_in <= 1'b0;
        cur_per <= 8'hFF;
        repeat (3) @(posedge clk_in);
        reset_n_in <= 1'b1;
        @(posedge clk_in);
        rdchk("count_rst", `PTPS_IDX_COUNT, 8'h00);
        rdchk("ctrl_rst", `PTPS_IDX_CTRL, 8'h00);
        rdchk("period_rst", `PTPS_IDX_PERIOD, 8'hFF);
        rdchk("flags_rst", `PTPS_IDX_FLAGS, 8'h00);
        rdchk("enables_rst", `PTPS_IDX_ENABLES, 8'h00);
        rdchk("intctl_rst", `PTPS_IDX_INTCTL, 8'h00);
    endtask

    function automatic logic [31:0] exp_gap(input logic [1:0] p, input logic [7:0] pv);
        logic [31:0] ps;
        ps = (p == 2'h0) ? 32'h1 : ((p == 2'h1) ? 32'h4 : 32'h10);
        exp_gap = ({30'h0, `PTPS_CORE_DIV} + 32'h1) * ps * ({24'h0, pv} + 32'h1);
    endfunction

    // ********************
    // Main sequence
    // ********************
    initial begin
        seed = 51;
        clk_en_in = 1'b1;
        psel_in = 1'b0;
        penable_in = 1'b0;
        pwrite_in = 1'b0;
        paddr_in = 32'h0;
        pwdata_in = 32'h0;
        pstrb_in = 4'hF;
        do_reset();
        wr(`PTPS_IDX_CTRL, 8'hFF);
        rdchk("ctrl_layout", `PTPS_IDX_CTRL, 8'h7F);
        wr(`PTPS_IDX_CTRL, 8'h00);
        apb(1'b0, 8'h13, 8'h00);
        check1("unmapped_err", 1'b1, err_q);
        checkv("unmapped_data", 32'h0, rdv);
        wr(`PTPS_IDX_COUNT, 8'h5A);
        rdchk("count_rw", `PTPS_IDX_COUNT, 8'h5A);
        pstrb_in <= 4'h0;
        wr(`PTPS_IDX_COUNT, 8'h33);
        pstrb_in <= 4'hF;
        wr(`PTPS_IDX_CTRL, 8'h78);
        rdchk("count_ctrl_write", `PTPS_IDX_COUNT, 8'h5A);
        repeat (100) @(posedge clk_in);
        rdchk("count_held", `PTPS_IDX_COUNT, 8'h5A);
        for (int k = 0; k < 6; k++) begin
            per = 8'(($random(seed) & 32'h7) + 32'h1);
            pre = 2'(($random(seed) & 32'hFF) % 32'h3);
            post = 4'($random(seed) & 32'h3);
            per = (k == 0) ? 8'h00 : ((k == 1) ? 8'hFF : per);
            pre = (k == 0) ? 2'h1 : ((k == 1) ? 2'h0 : ((k == 2) ? 2'h3 : pre));
            wr(`PTPS_IDX_CTRL, 8'h00);
            wr(`PTPS_IDX_COUNT, 8'h00);
            wr(`PTPS_IDX_PERIOD, per);
            cur_per <= per;
            wr(`PTPS_IDX_FLAGS, 8'h02);
            wr(`PTPS_IDX_ENABLES, 8'h02);
            p0 = pulses;
            wr(`PTPS_IDX_CTRL, {1'b0, post, 1'b1, pre});
            if (post != 4'h0) begin
                wait_pulses(p0 + int'(post));
                repeat (3) @(posedge clk_in);
                check1("irq_early", 1'b0, irq_out);
            end
            wait_pulses(p0 + int'(post) + 1);
            repeat (3) @(posedge clk_in);
            check1("irq_set", 1'b1, irq_out);
            wait_pulses(p0 + int'(post) + 3);
            checkv("match_gap", exp_gap(pre, per), gap);
            wr(`PTPS_IDX_CTRL, 8'h00);
            rdchk("flag_sticky", `PTPS_IDX_FLAGS, 8'h02);
            wr(`PTPS_IDX_FLAGS, 8'h02);
            repeat (2) @(posedge clk_in);
            check1("irq_cleared", 1'b0, irq_out);
        end
        // Postscaler of four matches, flag masked off from the interrupt line.
        wr(`PTPS_IDX_ENABLES, 8'h00);
        wr(`PTPS_IDX_COUNT, 8'h00);
        wr(`PTPS_IDX_PERIOD, 8'h03);
        cur_per <= 8'h03;
        wr(`PTPS_IDX_CTRL, 8'h1C);
        wait_pulses(pulses + 2);
        wr(`PTPS_IDX_COUNT, 8'h00);
        p0 = pulses;
        wait_pulses(p0 + 3);
        rdchk("flag_after_count_write", `PTPS_IDX_FLAGS, 8'h00);
        wait_pulses(p0 + 4);
        repeat (3) @(posedge clk_in);
        check1("irq_masked", 1'b0, irq_out);
        rdchk("flag_set", `PTPS_IDX_FLAGS, 8'h02);
        wr(`PTPS_IDX_ENABLES, 8'h02);
        repeat (2) @(posedge clk_in);
        check1("irq_unmasked", 1'b1, irq_out);
        wr(`PTPS_IDX_FLAGS, 8'h02);
        wait_pulses(pulses + 2);
        wr(`PTPS_IDX_CTRL, 8'h1C);
        p0 = pulses;
        wait_pulses(p0 + 3);
        rdchk("flag_after_ctrl_write", `PTPS_IDX_FLAGS, 8'h00);
        check1("irq_clear", 1'b0, irq_out);
        do_reset();
        tally_and_finish();
    end
endmodule
`default_nettype wire
